// ==== design/fsc_map.svh ====
// register offsets, field positions, reset values and timing counts of the fault status collector
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// register byte offsets
`define FSC_ADDR_STATUS_ONE 8'h00
`define FSC_ADDR_STATUS_THREE 8'h04
`define FSC_ADDR_STATUS_FOUR 8'h08
`define FSC_ADDR_STATUS_SEVEN 8'h0c
`define FSC_ADDR_CONFIG 8'h10
`define FSC_ADDR_IRQ_MASK 8'h14
`define FSC_ADDR_IRQ_STATUS 8'h18
`define FSC_ADDR_LIVE 8'h1c

// status_word_four field positions
`define FSC_S4_SERIAL_ERR 0
`define FSC_S4_EXC_OV 1
`define FSC_S4_EXC_INVALID 2
`define FSC_S4_SELFTEST_FAIL 3
`define FSC_S4_ALARM_MISMATCH 4
`define FSC_S4_ALARM_MONITOR 5

// status_word_one field positions
`define FSC_S1_SERIAL_CODE_LO 0
`define FSC_S1_SERIAL_CODE_HI 1

// config register field positions
`define FSC_CFG_AMP_LO 0
`define FSC_CFG_AMP_HI 1
`define FSC_CFG_LEVEL 2
`define FSC_CFG_BOOST_MASK 3

// reset values
`define FSC_CONFIG_RESET 4'h1
`define FSC_MASK_RESET 4'h0

// valid amplitude select codes
`define FSC_AMP_CODE_A 2'h1
`define FSC_AMP_CODE_B 2'h2

// serial error codes
`define FSC_SER_NONE 2'h0
`define FSC_SER_CHECKSUM 2'h1
`define FSC_SER_MISMATCH 2'h2
`define FSC_SER_BADADDR 2'h3

// timing: crystal check window
`define FSC_CLK_HZ 25000000
`define FSC_XTAL_HZ 20000000
`define FSC_WINDOW_US 100
`define FSC_WINDOW_CYC ((`FSC_CLK_HZ / 1000000) * `FSC_WINDOW_US)
`define FSC_XTAL_EXPECT ((`FSC_XTAL_HZ / 1000000) * `FSC_WINDOW_US)
`define FSC_XTAL_TOL 16'h0004

`endif

// ==== design/fsc_pkg.sv ====
// types shared by the fault status collector
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_BIST_IDLE,
    FSC_BIST_COUNT,
    FSC_BIST_DONE
  } fsc_bist_e;

  typedef logic [7:0] fsc_word_t;
endpackage

// ==== design/fsc_sticky.sv ====
// sticky fault flag with clear-on-read and alarm-clear wipe
`timescale 1ns/1ns
module fsc_sticky (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic clear_rd,
  input wire logic wipe,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } fsc_sticky_s;

  fsc_sticky_s st;
  fsc_sticky_s next_st;

  always_comb begin
    next_st = st;
    if (wipe) begin
      next_st.flag = 1'b0;
    end else if (event_in) begin
      // set beats the read clear
      next_st.flag = 1'b1;
    end else if (clear_rd) begin
      next_st.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;
endmodule // fsc_sticky

// ==== design/fsc_selftest.sv ====
// startup analog self-test: supply presence and crystal frequency check
`timescale 1ns/1ns
`include "fsc_map.svh"
module fsc_selftest (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic external_clock_select,
  input wire logic xtal_tick,
  input wire logic exciter_supply_present,
  input wire logic boost_supply_check_mask,
  output logic done,
  output logic fail
);
  typedef struct packed {
    fsc_pkg::fsc_bist_e state;
    logic [15:0] cycles;
    logic [15:0] ticks;
    logic done;
    logic fail;
  } fsc_bist_s;

  fsc_bist_s st;
  fsc_bist_s next_st;
  logic xtal_bad;
  logic supply_bad;

  always_comb begin
    next_st = st;
    // done is a one-cycle pulse, so a stale result re-sets the sticky flag only on a rearm
    next_st.done = 1'b0;
    xtal_bad = (st.ticks + `FSC_XTAL_TOL < 16'(`FSC_XTAL_EXPECT)) ||
               (st.ticks > 16'(`FSC_XTAL_EXPECT) + `FSC_XTAL_TOL);
    // unpowered supply tolerated when masked
    supply_bad = !exciter_supply_present && !boost_supply_check_mask;
    unique case (st.state)
      fsc_pkg::FSC_BIST_IDLE: begin
        if (start) begin
          next_st.state = fsc_pkg::FSC_BIST_COUNT;
          next_st.cycles = '0;
          next_st.ticks = '0;
          next_st.done = 1'b0;
        end
      end
      fsc_pkg::FSC_BIST_COUNT: begin
        next_st.cycles = st.cycles + 16'h0001;
        if (xtal_tick) begin
          next_st.ticks = st.ticks + 16'h0001;
        end
        if (st.cycles == 16'(`FSC_WINDOW_CYC - 1)) begin
          next_st.state = fsc_pkg::FSC_BIST_DONE;
        end
      end
      fsc_pkg::FSC_BIST_DONE: begin
        // crystal must run at 20 MHz when selected
        next_st.fail = supply_bad || (external_clock_select && xtal_bad);
        next_st.done = 1'b1;
        next_st.state = fsc_pkg::FSC_BIST_IDLE;
      end
      default: begin
        next_st.state = fsc_pkg::FSC_BIST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign fail = st.fail;
endmodule // fsc_selftest

// ==== design/fsc_collector.sv ====
// fault status collector: sticky fault flags, clear-on-read status words, interrupt
`timescale 1ns/1ns
`include "fsc_map.svh"
module fsc_collector (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic alarm_clear_input,
  input wire logic frame_done,
  input wire logic [1:0] frame_error_code,
  input wire logic [7:0] exciter_supply_pin,
  input wire logic [7:0] ov_limit_low,
  input wire logic [7:0] ov_limit_high,
  input wire logic alarm_pin_readback,
  input wire logic external_clock_select,
  input wire logic xtal_tick,
  input wire logic exciter_supply_present,
  input wire logic [1:0] fault_one_in,
  input wire logic fault_seven_in,
  output logic alarm_pin_drive,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam int NFLAG = 9;
  typedef struct packed {
    logic [3:0] config_reg;
    logic [3:0] mask;
    logic [1:0] serial_code;
    logic [7:0] rdata;
    logic clear_q;
    logic start_pending;
    logic alarm_drive;
    logic bist_live;
  } fsc_col_s;

  fsc_col_s st;
  fsc_col_s next_st;

  logic [1:0] amp_sel;
  logic level_sel;
  logic wipe;
  logic rearm;
  logic [NFLAG-1:0] cond;
  logic [NFLAG-1:0] rd_clr;
  logic [NFLAG-1:0] flag;
  logic [3:0] irq_status;
  logic bist_done;
  logic bist_fail;
  logic bist_fail_live;
  logic ov_live;
  logic rd_one;
  logic rd_three;
  logic rd_four;
  logic rd_seven;

  assign amp_sel = st.config_reg[`FSC_CFG_AMP_HI:`FSC_CFG_AMP_LO];
  assign level_sel = st.config_reg[`FSC_CFG_LEVEL];
  assign wipe = !alarm_clear_input;
  assign rearm = alarm_clear_input && st.clear_q;

  // ------------------------------------------------------------
  // fault conditions
  // ------------------------------------------------------------
  // limit follows the programmed supply level
  assign ov_live = level_sel ? (exciter_supply_pin > ov_limit_high)
                             : (exciter_supply_pin > ov_limit_low);

  // self-test fail stays live so a rearm re-reports it
  assign bist_fail_live = st.bist_live;

  assign rd_one = reg_rd && reg_addr == `FSC_ADDR_STATUS_ONE;
  assign rd_three = reg_rd && reg_addr == `FSC_ADDR_STATUS_THREE;
  assign rd_four = reg_rd && reg_addr == `FSC_ADDR_STATUS_FOUR;
  assign rd_seven = reg_rd && reg_addr == `FSC_ADDR_STATUS_SEVEN;

  // level conditions are re-sampled on rearm; event-type ones only on their event
  always_comb begin
    cond = '0;
    cond[`FSC_S4_SERIAL_ERR] = frame_done && frame_error_code != `FSC_SER_NONE;
    cond[`FSC_S4_EXC_OV] = ov_live;
    cond[`FSC_S4_EXC_INVALID] = amp_sel != `FSC_AMP_CODE_A && amp_sel != `FSC_AMP_CODE_B;
    cond[`FSC_S4_SELFTEST_FAIL] = (bist_done && bist_fail) || (rearm && bist_fail_live);
    cond[`FSC_S4_ALARM_MISMATCH] = alarm_pin_readback != st.alarm_drive;
    cond[`FSC_S4_ALARM_MONITOR] = !alarm_pin_readback;
    cond[6] = fault_one_in[0];
    cond[7] = fault_one_in[1];
    cond[8] = fault_seven_in;
  end

  always_comb begin
    rd_clr = '0;
    rd_clr[5:0] = {6{rd_four}};
    rd_clr[7:6] = {2{rd_one}};
    rd_clr[8] = rd_seven;
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      fsc_sticky u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(cond[gi]),
        .clear_rd(rd_clr[gi]),
        .wipe(wipe),
        .flag(flag[gi])
      );
    end
  endgenerate

  fsc_selftest u_bist (
    .clk(clk),
    .rst_n(rst_n),
    .start(st.start_pending),
    .external_clock_select(external_clock_select),
    .xtal_tick(xtal_tick),
    .exciter_supply_present(exciter_supply_present),
    .boost_supply_check_mask(st.config_reg[`FSC_CFG_BOOST_MASK]),
    .done(bist_done),
    .fail(bist_fail)
  );

  assign irq_status = {|flag[8:6], flag[`FSC_S4_SELFTEST_FAIL],
                       |{flag[`FSC_S4_ALARM_MONITOR:`FSC_S4_ALARM_MISMATCH], flag[`FSC_S4_EXC_INVALID]},
                       |flag[`FSC_S4_EXC_OV:`FSC_S4_SERIAL_ERR]};

  // ------------------------------------------------------------
  // register bus and control
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.clear_q = wipe;
    next_st.start_pending = 1'b0;
    if (bist_done) begin
      next_st.bist_live = bist_fail;
    end
    // alarm pin is driven low while an overvoltage, invalid amplitude or self-test fail flag is set
    next_st.alarm_drive = ~|flag[`FSC_S4_SELFTEST_FAIL:`FSC_S4_EXC_OV];
    if (frame_done) begin
      next_st.serial_code = frame_error_code;
    end
    if (wipe) begin
      next_st.serial_code = `FSC_SER_NONE;
    end else if (rd_one && !frame_done) begin
      next_st.serial_code = `FSC_SER_NONE;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `FSC_ADDR_CONFIG: begin
          next_st.config_reg = reg_wdata[3:0];
          next_st.start_pending = 1'b1;
        end
        `FSC_ADDR_IRQ_MASK: begin
          next_st.mask = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `FSC_ADDR_STATUS_ONE: next_st.rdata = {4'h0, flag[7:6], st.serial_code};
        `FSC_ADDR_STATUS_THREE: next_st.rdata = 8'h00;
        `FSC_ADDR_STATUS_FOUR: next_st.rdata = {2'h0, flag[5:0]};
        `FSC_ADDR_STATUS_SEVEN: next_st.rdata = {7'h00, flag[8]};
        `FSC_ADDR_CONFIG: next_st.rdata = {4'h0, st.config_reg};
        `FSC_ADDR_IRQ_MASK: next_st.rdata = {4'h0, st.mask};
        `FSC_ADDR_IRQ_STATUS: next_st.rdata = {4'h0, irq_status};
        `FSC_ADDR_LIVE: next_st.rdata = {6'h00, bist_fail_live, alarm_pin_readback};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.config_reg <= `FSC_CONFIG_RESET;
      st.mask <= `FSC_MASK_RESET;
      st.serial_code <= `FSC_SER_NONE;
      st.rdata <= 8'h00;
      st.clear_q <= 1'b0;
      st.start_pending <= 1'b1;
      st.alarm_drive <= 1'b1;
      st.bist_live <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign alarm_pin_drive = st.alarm_drive;
  assign irq = |(irq_status & st.mask);
endmodule // fsc_collector

// ==== tb/fsc_collector_sva.sv ====
// assertions on the fault status collector ports
`timescale 1ns/1ns
module fsc_collector_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic alarm_clear_input,
  input wire logic frame_done,
  input wire logic [1:0] frame_error_code,
  input wire logic alarm_pin_readback,
  input wire logic alarm_pin_drive,
  input wire logic fault_seven_in
);
  wire logic r00 = reg_rd && reg_addr == 8'h00;
  wire logic r08 = reg_rd && reg_addr == 8'h08;
  wire logic r0c = reg_rd && reg_addr == 8'h0c;
  wire logic aci = alarm_clear_input;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_WIPE: assert property (!aci && !$past(aci) && reg_rd && reg_addr < 8'h10 |=> reg_rdata == 8'h00)
    else $error("status not zero during wipe");
  AST_REREPORT: assert property ($rose(aci) && fault_seven_in ##1 r0c |=> reg_rdata[0])
    else $error("live fault not reported");
  AST_READ_CLEAR: assert property (r0c && !fault_seven_in ##1 r0c |=> reg_rdata == 8'h00)
    else $error("status not cleared by read");
  AST_STICKY: assert property (fault_seven_in && aci ##1 (aci && !reg_rd) [*2] ##1 r0c |=> reg_rdata[0])
    else $error("fault flag lost");
  AST_SUMMARY: assert property (frame_done && frame_error_code != 2'h0 && aci ##1 r08 |=> reg_rdata[0])
    else $error("serial summary not set");
  AST_CODE: assert property (frame_done && frame_error_code != 2'h0 && aci ##1 aci && !frame_done && !r00
    ##1 r00 |=> reg_rdata[1:0] == $past(frame_error_code, 3)) else $error("serial code wrong");
  AST_INVALID: assert property (reg_wr && reg_addr == 8'h10 && !(reg_wdata[1:0] inside {2'h1, 2'h2})
    ##1 aci && !reg_wr ##1 r08 |=> reg_rdata[2]) else $error("invalid amplitude not flagged");
  AST_MISMATCH: assert property (alarm_pin_readback != alarm_pin_drive && aci ##1 r08 |=> reg_rdata[4])
    else $error("alarm mismatch not flagged");
  AST_MONITOR: assert property (!alarm_pin_readback && aci ##1 r08 |=> reg_rdata[5])
    else $error("alarm monitor not set");
  cover property (r0c ##1 r0c);
  cover property ($rose(aci) ##1 r0c);
  cover property (frame_done && frame_error_code == 2'h3);
endmodule // fsc_collector_sva

// ==== tb/fsc_host_model.sv ====
// host bus master model driving the register port
`timescale 1ns/1ns
module fsc_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // entered just after a rising edge; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask
endmodule // fsc_host_model

// ==== tb/test_fault_status_collector.sv ====
// self-checking bench of the fault status collector
`timescale 1ns/1ns
module test_fault_status_collector;
  logic clk = 1'b0, rst_n = 1'b0, alarm_clear_input = 1'b1, frame_done = 1'b0;
  logic fault_seven_in = 1'b0, xtal_tick = 1'b0, external_clock_select = 1'b1;
  logic exciter_supply_present = 1'b1, tick_ok = 1'b1;
  logic [1:0] frame_error_code = 2'h0, fault_one_in = 2'h0, smode = 2'h0, cd;
  logic [2:0] tcnt = 3'h0;
  logic [7:0] exciter_supply_pin = 8'h00, ov_limit_low = 8'hff, ov_limit_high = 8'hff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, alarm_pin_drive, irq, alarm_pin_readback;
  logic [31:0] lfsr = 32'h6507bb5b;
  // {supply present, boost mask, crystal ok, crystal select, expected fail}
  logic [4:0] st [5] = '{5'h16, 5'h07, 5'h0e, 5'h10, 5'h13};
  int miscompares = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  // shorted pin reads inverted or stuck low
  assign alarm_pin_readback = (smode == 2'h2) ? 1'b0 : alarm_pin_drive ^ (smode == 2'h1);
  always @(posedge clk) begin
    tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    xtal_tick <= tick_ok && tcnt != 3'h4;
  end
  fsc_collector dut_u (.*);
  fsc_host_model host_u (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_ov(input logic [7:0] p, input logic [7:0] lo, input logic [7:0] hi, input logic l);
    return p > (l ? hi : lo);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  // first read drops a stale sticky bit
  task automatic rd2(input logic [7:0] a);
    host_u.rd(a, d);
    host_u.rd(a, d);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    step(10);
    rst_n <= 1'b1;
    step(1);
    host_u.rd(8'h10, d);
    chk8("config", 8'h01, d);
    host_u.rd(8'h20, d);
    chk8("unmapped", 8'h00, d);
    host_u.rd(8'h04, d);
    chk8("status_three", 8'h00, d);
    for (int i = 0; i < 5; i++) begin
      {exciter_supply_present, tick_ok, external_clock_select} <= {st[i][4], st[i][2:1]};
      host_u.wr(8'h10, {4'h0, st[i][3], 3'h1});
      step(2600);
      host_u.rd(8'h1c, d);
      chk1("selftest_fail", st[i][0], d[1]);
    end
    for (int c = 0; c < 4; c++) begin
      host_u.wr(8'h10, {6'h00, c[1:0]});
      step(1);
      rd2(8'h08);
      chk1("amp_invalid", c[1:0] != 2'h1 && c[1:0] != 2'h2, d[2]);
      chk1("alarm_drive", c[1:0] == 2'h1 || c[1:0] == 2'h2, alarm_pin_drive);
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      exciter_supply_pin <= lfsr[7:0];
      // first passes sit exactly on the limit, which must not trip
      ov_limit_low <= (i < 2) ? lfsr[7:0] : lfsr[15:8];
      ov_limit_high <= (i < 2) ? lfsr[7:0] : lfsr[23:16];
      host_u.wr(8'h10, {5'h00, i[0], 2'h1});
      step(1);
      rd2(8'h08);
      chk1("supply_ov", exp_ov(exciter_supply_pin, ov_limit_low, ov_limit_high, i[0]), d[1]);
    end
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      cd = (i < 4) ? 2'(i) : lfsr[1:0];
      fault_one_in <= lfsr[3:2];
      frame_done <= 1'b1;
      frame_error_code <= cd;
      step(1);
      frame_done <= 1'b0;
      frame_error_code <= ~cd;
      host_u.rd(8'h08, d);
      chk1("serial_sum", cd != 2'h0, d[0]);
      host_u.rd(8'h00, d);
      chk8("serial_code", {6'h00, cd}, d & 8'h03);
      host_u.rd(8'h00, d);
      chk8("code_cleared", {4'h0, fault_one_in, 2'h0}, d & 8'h0f);
    end
    fault_one_in <= 2'h0;
    fault_seven_in <= 1'b1;
    alarm_clear_input <= 1'b0;
    step(2);
    host_u.rd(8'h0c, d);
    chk1("wiped", 1'b0, d[0]);
    alarm_clear_input <= 1'b1;
    step(1);
    host_u.rd(8'h0c, d);
    chk1("rereport", 1'b1, d[0]);
    host_u.rd(8'h08, d);
    chk1("rereport_selftest", 1'b1, d[3]);
    fault_seven_in <= 1'b0;
    step(2);
    host_u.rd(8'h0c, d);
    chk1("sticky", 1'b1, d[0]);
    host_u.rd(8'h0c, d);
    chk1("read_clear", 1'b0, d[0]);
    smode <= 2'h1;
    step(1);
    host_u.rd(8'h08, d);
    chk1("alarm_mismatch", 1'b1, d[4]);
    smode <= 2'h2;
    step(1);
    host_u.rd(8'h08, d);
    chk1("alarm_monitor", 1'b1, d[5]);
    smode <= 2'h0;
    host_u.wr(8'h14, 8'h08);
    fault_seven_in <= 1'b1;
    step(1);
    fault_seven_in <= 1'b0;
    step(1);
    chk1("irq_on", 1'b1, irq);
    host_u.rd(8'h18, d);
    chk1("irq_status", 1'b1, d[3]);
    host_u.rd(8'h0c, d);
    chk1("irq_off", 1'b0, irq);
    host_u.wr(8'h14, 8'h00);
    fault_seven_in <= 1'b1;
    step(2);
    chk1("irq_masked", 1'b0, irq);
    close_out();
  end
  // run needs about 13100 cycles
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
endmodule // test_fault_status_collector
bind fsc_collector fsc_collector_sva chk_u (.*);
